// ===== rtl/kbl_pkg.sv
// Shared constants and types for the keyboard scan-code link
package kbl_pkg;
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int H2K_BAUD      = 305;
  localparam int K2H_BAUD      = 2440;
  localparam int H2K_BIT_CYC   = CLK_HZ / H2K_BAUD;
  localparam int K2H_BIT_CYC   = CLK_HZ / K2H_BAUD;
  localparam int REPEAT_DELAY_MS  = 500;
  localparam int REPEAT_PERIOD_MS = 100;
  localparam int REPEAT_DELAY_CYC  = CLK_HZ / 1000 * REPEAT_DELAY_MS;
  localparam int REPEAT_PERIOD_CYC = CLK_HZ / 1000 * REPEAT_PERIOD_MS;
  localparam int SETTLE_NS     = 160;
  localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MATRIX_ROWS   = 7;
  localparam int MATRIX_COLS   = 16;
  localparam bit ODD_PARITY_DEFAULT = 1'b1;
  // Frame: start, 8 data LSB first, parity, stop
  localparam int FRAME_BITS    = 11;
  localparam int FR_DATA_LSB   = 1;
  localparam int FR_PAR        = 9;
  localparam int FR_STOP       = 10;
  // Link bytes
  localparam logic [7:0] CMD_SELFTEST = 8'h01;
  localparam logic [7:0] CMD_READY    = 8'h02;
  localparam logic [7:0] STAT_OK      = 8'hAA;
  localparam logic [7:0] STAT_FAIL    = 8'hFC;
  localparam logic [3:0] MODE_ID      = 4'hF;
  localparam int REPEAT_BIT    = 7;
  // Modifier bits in the mode nibble and their key positions
  localparam int MOD_SHIFT     = 0;
  localparam int MOD_ALT       = 1;
  localparam int MOD_CAPS      = 2;
  localparam int MOD_CTRL      = 3;
  localparam logic [6:0] KEY_SHIFT = 7'h60;
  localparam logic [6:0] KEY_ALT   = 7'h61;
  localparam logic [6:0] KEY_CAPS  = 7'h62;
  localparam logic [6:0] KEY_CTRL  = 7'h63;
  // Host register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_KEY    = 4'h8;
  localparam int CTRL_TEST_BIT  = 0;
  localparam int CTRL_READY_BIT = 1;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_PASS_BIT    = 1;
  localparam int ST_KEY_BIT     = 2;
  localparam int ST_ERR_BIT     = 3;
  localparam int ST_BUSY_BIT    = 4;
  localparam int KEY_MODS_LSB   = 8;

  typedef enum logic [6:0] {
    KS_IDLE    = 7'h01,
    KS_TEST    = 7'h02,
    KS_STAT_TX = 7'h04,
    KS_WAIT    = 7'h08,
    KS_SCAN    = 7'h10,
    KS_MODE_TX = 7'h20,
    KS_CODE_TX = 7'h40
  } kbl_kstate_type;

  function automatic logic parityOf(input logic [7:0] d, input logic odd);
    return odd ? ~^d : ^d;
  endfunction
endpackage

// ===== rtl/kbl_if.sv
// Two serial lines between keyboard and host
`timescale 1ns/1ps
interface kbl_if;
  logic kbdToHost;
  logic hostToKbd;
  modport keyboard(output kbdToHost, input hostToKbd);
  modport host(input kbdToHost, output hostToKbd);
endinterface

// ===== rtl/kbl_uart.sv
// Asynchronous 11-bit frame transmitter and receiver
`timescale 1ns/1ps
module kbl_uart #(
  parameter int TX_CYC     = kbl_pkg::K2H_BIT_CYC,
  parameter int RX_CYC     = kbl_pkg::H2K_BIT_CYC,
  parameter bit ODD_PARITY = kbl_pkg::ODD_PARITY_DEFAULT
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Transmit side
  input  wire logic       txStart,
  input  wire logic [7:0] txData,
  output logic            txBusy,
  output logic            txLine,
  // Receive side
  input  wire logic       rxLine,
  output logic [7:0]      rxData,
  output logic            rxValid,
  output logic            rxErr
);
  import kbl_pkg::*;
  localparam int TW = $clog2(TX_CYC + 1);
  localparam int RW = $clog2(RX_CYC + 1);
  localparam logic [TW-1:0] TX_RELOAD = TW'(TX_CYC - 1);
  localparam logic [RW-1:0] RX_RELOAD = RW'(RX_CYC - 1);
  localparam logic [RW-1:0] RX_HALF   = RW'(RX_CYC / 2);
  localparam logic [3:0]    BITS_LAST = 4'(FRAME_BITS - 1);

  logic [9:0]            txShift_q;
  logic [3:0]            txBits_q;
  logic [TW-1:0]         txCnt_q;
  logic                  rxBusy_q;
  logic [3:0]            rxBits_q;
  logic [RW-1:0]         rxCnt_q;
  logic [FRAME_BITS-1:0] rxShift_q;
  logic [FRAME_BITS-1:0] rxNext;
  logic                  rxBad;

  assign rxNext = {rxLine, rxShift_q[FRAME_BITS-1:1]};
  assign rxBad  = !rxNext[FR_STOP] ||
                  (rxNext[FR_PAR] !=
                   parityOf(rxNext[FR_PAR-1:FR_DATA_LSB], ODD_PARITY));

  // Line idles at mark; LSB first with parity before stop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txLine    <= 1'b1;
      txBusy    <= 1'b0;
      txShift_q <= '0;
      txBits_q  <= '0;
      txCnt_q   <= '0;
    end else if (!txBusy && txStart) begin
      txShift_q <= {1'b1, parityOf(txData, ODD_PARITY), txData};
      txLine    <= 1'b0;
      txBusy    <= 1'b1;
      txBits_q  <= BITS_LAST;
      txCnt_q   <= TX_RELOAD;
    end else if (txBusy) begin
      if (txCnt_q != '0) begin
        txCnt_q <= txCnt_q - 1'b1;
      end else if (txBits_q == '0) begin
        txBusy <= 1'b0;
      end else begin
        txLine    <= txShift_q[0];
        txShift_q <= {1'b1, txShift_q[9:1]};
        txBits_q  <= txBits_q - 1'b1;
        txCnt_q   <= TX_RELOAD;
      end
    end
  end

  // Samples mid-bit; a start bit gone high at its middle is a glitch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxBusy_q  <= 1'b0;
      rxBits_q  <= '0;
      rxCnt_q   <= '0;
      rxShift_q <= '0;
      rxData    <= '0;
      rxValid   <= 1'b0;
      rxErr     <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      rxErr   <= 1'b0;
      if (!rxBusy_q) begin
        if (!rxLine) begin
          rxBusy_q <= 1'b1;
          rxBits_q <= '0;
          rxCnt_q  <= RX_HALF;
        end
      end else if (rxCnt_q != '0) begin
        rxCnt_q <= rxCnt_q - 1'b1;
      end else if (rxBits_q == '0 && rxLine) begin
        rxBusy_q <= 1'b0;
      end else begin
        rxShift_q <= rxNext;
        rxCnt_q   <= RX_RELOAD;
        rxBits_q  <= rxBits_q + 1'b1;
        if (rxBits_q == BITS_LAST) begin
          rxBusy_q <= 1'b0;
          rxData   <= rxNext[FR_PAR-1:FR_DATA_LSB];
          rxValid  <= !rxBad;
          rxErr    <= rxBad;
        end
      end
    end
  end
endmodule

// ===== rtl/kbl_keyboard.sv
// Keyboard end: matrix scan, self-test handshake, scan-code reports
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Host asks for keyboard self-test at power-up
// - Keyboard tests itself, returns OK or Not OK
// - Host signals ready; keyboard waits before reporting
// - Host to keyboard runs at 305 baud
// - Keyboard to host runs at 2440 baud
// - Keys found by driving scan, sensing returns
// - Keys reported as position codes, never characters
// - Each key event gives one or two bytes
// - Shift, alternate, capitals latch, control are modifiers
// - Mode byte sent only when modifiers changed
// - Mode byte always followed by scan byte
// - During auto-repeat modifiers frozen, no mode byte
// - Mode byte: identifier, four modifier bits, parity
// - Scan byte: seven-bit code, repeat bit, parity
module kbl_keyboard #(
  parameter int ROWS          = kbl_pkg::MATRIX_ROWS,
  parameter int COLS          = kbl_pkg::MATRIX_COLS,
  parameter int TX_CYC        = kbl_pkg::K2H_BIT_CYC,
  parameter int RX_CYC        = kbl_pkg::H2K_BIT_CYC,
  parameter int REPEAT_DELAY  = kbl_pkg::REPEAT_DELAY_CYC,
  parameter int REPEAT_PERIOD = kbl_pkg::REPEAT_PERIOD_CYC,
  parameter bit ODD_PARITY    = kbl_pkg::ODD_PARITY_DEFAULT
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            nrst,
  // Link to the host
  kbl_if.keyboard              link,
  // Key-switch matrix
  output logic [ROWS-1:0]      scanDrive,
  input  wire logic [COLS-1:0] returnSense,
  // Status
  output logic                 hostReady
);
  import kbl_pkg::*;
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(COLS);
  // Timer sized for the longer of delay and period, so neither load wraps
  localparam int TW = $clog2((REPEAT_DELAY > REPEAT_PERIOD ?
                              REPEAT_DELAY : REPEAT_PERIOD) + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam int KEYS = ROWS * COLS;
  localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);
  localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);
  localparam logic [SW-1:0] SETTLE_RELOAD = SW'(SETTLE_CYC - 1);
  localparam logic [TW-1:0] DELAY_LOAD  = TW'(REPEAT_DELAY);
  localparam logic [TW-1:0] PERIOD_LOAD = TW'(REPEAT_PERIOD);

  kbl_kstate_type state_q;
  logic [RW-1:0]   rowIdx_q;
  logic [CW-1:0]   colIdx_q;
  logic [SW-1:0]   settle_q;
  logic [KEYS-1:0] keyDown_q;
  logic [3:0]      mods_q;
  logic [3:0]      lastMods_q;
  logic [6:0]      pendCode_q;
  logic            pendRep_q;
  logic [6:0]      heldCode_q;
  logic            heldValid_q;
  logic            repeatOn_q;
  logic [TW-1:0]   repTimer_q;
  logic            testFail_q;
  logic            launched_q;
  logic            txBusy;
  logic            txLine;
  logic [7:0]      rxData;
  logic            rxValid;
  logic [7:0]      txByte;
  logic [6:0]      keyIdx;
  logic            scanning;
  logic            sample;
  logic            closed;
  logic            wasDown;
  logic            lastKey;
  logic            isMod;
  logic            canTest;
  logic            gotTest;
  logic            gotReady;
  logic            newPress;
  logic            repeatDue;
  logic            txState;
  logic            txGo;
  logic            txDone;

  // Position code from row and column; never a character
  function automatic logic [6:0] codeOf(input logic [RW-1:0] r,
                                         input logic [CW-1:0] c);
    return 7'(int'(r) * COLS + int'(c));
  endfunction

  // Link bit rates: 2440 out, 305 in
  kbl_uart #(
    .TX_CYC     (TX_CYC),
    .RX_CYC     (RX_CYC),
    .ODD_PARITY (ODD_PARITY)
  ) uart (
    .clock   (clock),
    .nrst    (nrst),
    .txStart (txGo),
    .txData  (txByte),
    .txBusy  (txBusy),
    .txLine  (txLine),
    .rxLine  (link.hostToKbd),
    .rxData  (rxData),
    .rxValid (rxValid),
    .rxErr   ()
  );
  assign link.kbdToHost = txLine;

  assign keyIdx   = codeOf(rowIdx_q, colIdx_q);
  assign scanning = (state_q == KS_TEST) || (state_q == KS_SCAN);
  assign sample   = scanning && (settle_q == '0);
  assign closed   = returnSense[colIdx_q];
  assign wasDown  = keyDown_q[keyIdx];
  assign lastKey  = (rowIdx_q == ROW_LAST) && (colIdx_q == COL_LAST);
  // Exactly four modifier positions
  assign isMod    = (keyIdx == KEY_SHIFT) || (keyIdx == KEY_ALT) ||
                    (keyIdx == KEY_CAPS) || (keyIdx == KEY_CTRL);
  assign canTest  = (state_q == KS_IDLE) || (state_q == KS_WAIT) ||
                    (state_q == KS_SCAN);
  assign gotTest  = canTest && rxValid && (rxData == CMD_SELFTEST);
  assign gotReady = rxValid && (rxData == CMD_READY);
  assign newPress = sample && (state_q == KS_SCAN) && !gotTest &&
                    closed && !wasDown && !isMod;
  assign repeatDue = (state_q == KS_SCAN) && !gotTest && !newPress &&
                     heldValid_q && (repTimer_q == '0);
  assign txState  = (state_q == KS_STAT_TX) || (state_q == KS_MODE_TX) ||
                    (state_q == KS_CODE_TX);
  assign txGo     = txState && !launched_q && !txBusy;
  assign txDone   = txState && launched_q && !txBusy;

  // Frame contents
  always_comb begin
    case (state_q)
      KS_STAT_TX: txByte = testFail_q ? STAT_FAIL : STAT_OK;
      KS_MODE_TX: txByte = {MODE_ID, lastMods_q};
      default:    txByte = {pendRep_q, pendCode_q};
    endcase
  end

  // Handshake and report sequencing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= KS_IDLE;
    end else begin
      case (state_q)
        KS_IDLE: begin
          if (gotTest) state_q <= KS_TEST;
        end
        KS_TEST: begin
          if (sample && lastKey) state_q <= KS_STAT_TX;
        end
        KS_STAT_TX: begin
          if (txDone) state_q <= KS_WAIT;
        end
        KS_WAIT: begin
          if (gotTest) begin
            state_q <= KS_TEST;
          end else if (gotReady) begin
            state_q <= KS_SCAN;
          end
        end
        KS_SCAN: begin
          if (gotTest) begin
            state_q <= KS_TEST;
          end else if (newPress && (mods_q != lastMods_q)) begin
            state_q <= KS_MODE_TX;
          end else if (newPress || repeatDue) begin
            state_q <= KS_CODE_TX;
          end
        end
        KS_MODE_TX: begin
          if (txDone) state_q <= KS_CODE_TX;
        end
        KS_CODE_TX: begin
          if (txDone) state_q <= KS_SCAN;
        end
        default: state_q <= KS_IDLE;
      endcase
    end
  end

  // One frame per transmit state; busy rises the edge after txGo
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      launched_q <= 1'b0;
    end else if (txGo) begin
      launched_q <= 1'b1;
    end else if (txDone) begin
      launched_q <= 1'b0;
    end
  end

  // Matrix walk: one position per settle window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rowIdx_q  <= '0;
      colIdx_q  <= '0;
      settle_q  <= SETTLE_RELOAD;
      scanDrive <= '0;
    end else begin
      scanDrive <= scanning ? (ROWS'(1) << rowIdx_q) : '0;
      if (gotTest) begin
        rowIdx_q <= '0;
        colIdx_q <= '0;
        settle_q <= SETTLE_RELOAD;
      end else if (scanning && settle_q != '0) begin
        settle_q <= settle_q - 1'b1;
      end else if (sample) begin
        settle_q <= SETTLE_RELOAD;
        if (colIdx_q == COL_LAST) begin
          colIdx_q <= '0;
          rowIdx_q <= (rowIdx_q == ROW_LAST) ? '0 : rowIdx_q + 1'b1;
        end else begin
          colIdx_q <= colIdx_q + 1'b1;
        end
      end
    end
  end

  // Keys held through the self-test are not reported afterwards
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      keyDown_q <= '0;
    end else if (sample) begin
      keyDown_q[keyIdx] <= closed;
    end
  end

  // A key closed during the self-test fails it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      testFail_q <= 1'b0;
    end else if (gotTest) begin
      testFail_q <= 1'b0;
    end else if (state_q == KS_TEST && sample && closed) begin
      testFail_q <= 1'b1;
    end
  end

  // Modifier tracking, frozen while repeating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mods_q <= '0;
    end else if (sample && state_q == KS_SCAN && !repeatOn_q) begin
      if (keyIdx == KEY_SHIFT) mods_q[MOD_SHIFT] <= closed;
      if (keyIdx == KEY_ALT)   mods_q[MOD_ALT]   <= closed;
      if (keyIdx == KEY_CTRL)  mods_q[MOD_CTRL]  <= closed;
      // Capitals latch toggles on each press
      if (keyIdx == KEY_CAPS && closed && !wasDown) begin
        mods_q[MOD_CAPS] <= !mods_q[MOD_CAPS];
      end
    end
  end

  // Pending report, held key and repeat timing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lastMods_q  <= '0;
      pendCode_q  <= '0;
      pendRep_q   <= 1'b0;
      heldCode_q  <= '0;
      heldValid_q <= 1'b0;
      repeatOn_q  <= 1'b0;
      repTimer_q  <= '0;
    end else if (gotTest) begin
      heldValid_q <= 1'b0;
      repeatOn_q  <= 1'b0;
    end else if (newPress) begin
      pendCode_q  <= keyIdx;
      pendRep_q   <= 1'b0;
      heldCode_q  <= keyIdx;
      heldValid_q <= 1'b1;
      repeatOn_q  <= 1'b0;
      repTimer_q  <= DELAY_LOAD;
      lastMods_q  <= mods_q;
    end else if (repeatDue) begin
      pendCode_q <= heldCode_q;
      pendRep_q  <= 1'b1;
      repeatOn_q <= 1'b1;
      repTimer_q <= PERIOD_LOAD;
    end else if (sample && state_q == KS_SCAN && heldValid_q &&
                 keyIdx == heldCode_q && !closed) begin
      heldValid_q <= 1'b0;
      repeatOn_q  <= 1'b0;
    end else if (state_q == KS_SCAN && heldValid_q &&
                 repTimer_q != '0) begin
      repTimer_q <= repTimer_q - 1'b1;
    end
  end

  // Ready seen; a new self-test request withdraws it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hostReady <= 1'b0;
    end else if (gotTest) begin
      hostReady <= 1'b0;
    end else if (state_q == KS_WAIT && gotReady) begin
      hostReady <= 1'b1;
    end
  end
endmodule

// ===== rtl/kbl_host.sv
// Host end: command sender, report receiver, software registers
`timescale 1ns/1ps
module kbl_host #(
  parameter int TX_CYC     = kbl_pkg::H2K_BIT_CYC,
  parameter int RX_CYC     = kbl_pkg::K2H_BIT_CYC,
  parameter bit ODD_PARITY = kbl_pkg::ODD_PARITY_DEFAULT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Link to the keyboard
  kbl_if.host              link,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata
);
  import kbl_pkg::*;

  logic       pendTest_q;
  logic       pendReady_q;
  logic       goPrev_q;
  logic       awaitStat_q;
  logic       testDone_q;
  logic       testPass_q;
  logic [3:0] curMods_q;
  logic [6:0] keyCode_q;
  logic       keyRep_q;
  logic [3:0] keyMods_q;
  logic       keyValid_q;
  logic       rxErrFlag_q;
  logic       txBusy;
  logic       txLine;
  logic       txGo;
  logic [7:0] rxData;
  logic       rxValid;
  logic       rxErr;
  logic       wrCtrl;
  logic       wrStatus;

  assign wrCtrl   = regWrite && (regAddr == REG_CTRL);
  assign wrStatus = regWrite && (regAddr == REG_STATUS);
  // Hold off one cycle after a launch until busy is visible
  assign txGo = (pendTest_q || pendReady_q) && !txBusy && !goPrev_q;

  kbl_uart #(
    .TX_CYC     (TX_CYC),
    .RX_CYC     (RX_CYC),
    .ODD_PARITY (ODD_PARITY)
  ) uart (
    .clock   (clock),
    .nrst    (nrst),
    .txStart (txGo),
    .txData  (pendTest_q ? CMD_SELFTEST : CMD_READY),
    .txBusy  (txBusy),
    .txLine  (txLine),
    .rxLine  (link.kbdToHost),
    .rxData  (rxData),
    .rxValid (rxValid),
    .rxErr   (rxErr)
  );
  assign link.hostToKbd = txLine;

  // Command queue: test request wins over ready
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pendTest_q  <= 1'b0;
      pendReady_q <= 1'b0;
      goPrev_q    <= 1'b0;
      awaitStat_q <= 1'b0;
    end else begin
      goPrev_q <= txGo;
      if (wrCtrl && regWdata[CTRL_TEST_BIT]) begin
        pendTest_q <= 1'b1;
      end else if (txGo && pendTest_q) begin
        pendTest_q <= 1'b0;
      end
      if (wrCtrl && regWdata[CTRL_READY_BIT]) begin
        pendReady_q <= 1'b1;
      end else if (txGo && !pendTest_q) begin
        pendReady_q <= 1'b0;
      end
      if (txGo && pendTest_q) begin
        awaitStat_q <= 1'b1;
      end else if (rxValid) begin
        awaitStat_q <= 1'b0;
      end
    end
  end

  // Report decoding; set wins over software clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      testDone_q  <= 1'b0;
      testPass_q  <= 1'b0;
      curMods_q   <= '0;
      keyCode_q   <= '0;
      keyRep_q    <= 1'b0;
      keyMods_q   <= '0;
      keyValid_q  <= 1'b0;
      rxErrFlag_q <= 1'b0;
    end else begin
      if (txGo && pendTest_q) begin
        testDone_q <= 1'b0;
      end else if (rxValid && awaitStat_q) begin
        testDone_q <= 1'b1;
        testPass_q <= (rxData == STAT_OK);
      end
      if (rxValid && !awaitStat_q && rxData[7:4] == MODE_ID) begin
        curMods_q <= rxData[3:0];
      end
      if (rxValid && !awaitStat_q && rxData[7:4] != MODE_ID) begin
        keyCode_q  <= rxData[6:0];
        keyRep_q   <= rxData[REPEAT_BIT];
        keyMods_q  <= curMods_q;
        keyValid_q <= 1'b1;
      end else if (regRead && regAddr == REG_KEY) begin
        keyValid_q <= 1'b0;
      end
      if (rxErr) begin
        rxErrFlag_q <= 1'b1;
      end else if (wrStatus && regWdata[ST_ERR_BIT]) begin
        rxErrFlag_q <= 1'b0;
      end
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else begin
      regRdata <= '0;
      if (regRead && regAddr == REG_STATUS) begin
        regRdata[ST_DONE_BIT] <= testDone_q;
        regRdata[ST_PASS_BIT] <= testPass_q;
        regRdata[ST_KEY_BIT]  <= keyValid_q;
        regRdata[ST_ERR_BIT]  <= rxErrFlag_q;
        regRdata[ST_BUSY_BIT] <= txBusy || pendTest_q || pendReady_q;
      end else if (regRead && regAddr == REG_KEY) begin
        regRdata[6:0]          <= keyCode_q;
        regRdata[REPEAT_BIT]   <= keyRep_q;
        regRdata[KEY_MODS_LSB +: 4] <= keyMods_q;
      end
    end
  end
endmodule

// ===== tb/kbl_link_sva.sv
// Framing checks on both serial lines
`timescale 1ns/1ps
module kbl_link_sva
  import kbl_pkg::*;
#(
  parameter int N0  = 40,
  parameter int N1  = 320,
  parameter bit ODD = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Lines
  input wire logic kbdToHost,
  input wire logic hostToKbd
);
  localparam int S0 = 10 * N0 + N0 / 2;
  localparam int S1 = 10 * N1 + N1 / 2;
  logic [15:0] c [2];
  logic [8:0]  s [2];
  logic [1:0]  ln;
  assign ln = {hostToKbd, kbdToHost};
  // Cycles since first low; cleared at stop middle
  always_ff @(posedge clock or negedge nrst) begin
    for (int i = 0; i < 2; i++) begin
      int n;
      n = i ? N1 : N0;
      if (!nrst) begin
        c[i] <= '0;
        s[i] <= '0;
      end else if (c[i] == 0) begin
        c[i] <= {15'h0, ~ln[i]};
      end else begin
        c[i] <= (c[i] == 10 * n + n / 2) ? '0 : c[i] + 1'b1;
        // Last nine mid samples keep data and parity
        if (c[i] % n == n / 2 && c[i] < 10 * n) begin
          s[i] <= {ln[i], s[i][8:1]};
        end
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_k2h_start_low: assert property (c[0] == N0 / 2 |-> !kbdToHost)
    else $error("k2h start bit high");
  a_k2h_stop_high: assert property (c[0] == S0 |-> kbdToHost)
    else $error("k2h stop bit low");
  a_k2h_parity: assert property (c[0] == S0 |-> ^s[0] == ODD)
    else $error("k2h parity wrong");
  a_k2h_bit_rate: assert property
    (c[0] != 0 && $changed(kbdToHost) |-> c[0] % N0 == 0)
    else $error("k2h edge off bit grid");
  // Fail status also starts with the mode nibble
  a_mode_then_scan: assert property (c[0] == S0 &&
    s[0][7:4] == MODE_ID && s[0][7:0] != STAT_FAIL |-> ##[1:N0] c[0] == 1)
    else $error("mode byte sent alone");
  a_h2k_stop_high: assert property (c[1] == S1 |-> hostToKbd)
    else $error("h2k stop bit low");
  a_h2k_parity: assert property (c[1] == S1 |-> ^s[1] == ODD)
    else $error("h2k parity wrong");
  a_h2k_bit_rate: assert property
    (c[1] != 0 && $changed(hostToKbd) |-> c[1] % N1 == 0)
    else $error("h2k edge off bit grid");
  cover property (c[0] == S0 && s[0][7:4] == MODE_ID);
  cover property (c[0] == S0 && s[0][7]);
  cover property (c[1] == S1);
endmodule

// ===== tb/test_keyboard_scan_code_link.sv
// Bench joining keyboard and host ends
`timescale 1ns/1ps
module test_keyboard_scan_code_link;
  import kbl_pkg::*;
  logic         clock = 1'b0;
  logic         nrst, regWrite, regRead, hostReady;
  logic [3:0]   regAddr;
  logic [31:0]  regWdata, regRdata, v;
  logic [6:0]   scanDrive;
  logic [15:0]  returnSense;
  logic [127:0] keys;
  int           mismatches, checked;
  kbl_if link ();
  // Repeat period left long: only the first repeat is exercised
  kbl_keyboard #(.TX_CYC(40), .RX_CYC(320), .REPEAT_DELAY(2000))
    u_kbl_keyboard (.clock(clock), .nrst(nrst),
    .link(link), .scanDrive(scanDrive), .returnSense(returnSense),
    .hostReady(hostReady));
  kbl_host #(.TX_CYC(320), .RX_CYC(40)) u_kbl_host (.clock(clock),
    .nrst(nrst), .link(link), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  // Checker defaults already equal the shortened bit times above
  kbl_link_sva u_kbl_link_sva (.clock(clock),
    .nrst(nrst), .kbdToHost(link.kbdToHost), .hostToKbd(link.hostToKbd));
  always #10 clock = ~clock;
  // Switch matrix: closed keys answer on their driven row
  always_comb begin
    returnSense = '0;
    for (int r = 0; r < 7; r++) begin
      if (scanDrive[r]) begin
        returnSense = returnSense | keys[r*16 +: 16];
      end
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask
  task automatic waitSt(input int b, output logic [31:0] d);
    d = '0;
    for (int n = 0; n < 4000 && d[b] !== 1'b1; n++) begin
      rd(REG_STATUS, d);
    end
  endtask
  // Modifier keys never report; skip reports of other keys
  task automatic readKey(input logic [6:0] k, output logic [31:0] d);
    d = '0;
    for (int n = 0; n < 4 && d[6:0] !== k; n++) begin
      waitSt(ST_KEY_BIT, d);
      rd(REG_KEY, d);
    end
  endtask
  task automatic tryKey(input logic [6:0] m, input logic [6:0] k,
      input logic [3:0] e);
    if (m != 0)
      keys[m] <= 1'b1;
    repeat (1000) @(posedge clock);
    keys[k] <= 1'b1;
    readKey(k, v);
    chk(v & 32'hFFF, {20'h0, e, 1'b0, k});
    keys <= '0;
    repeat (1000) @(posedge clock);
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    end_sim();
  end
  initial begin
    nrst = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWdata = '0;
    keys = '0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rd(REG_STATUS, v);
    chk(v, 32'h0);
    rd(4'hC, v);
    chk(v, 32'h0);
    keys[7'h15] <= 1'b1;
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, v);
    chk(v & 32'h10, 32'h10);
    waitSt(ST_DONE_BIT, v);
    chk(v & 32'h3, 32'h1);
    keys <= '0;
    wr(REG_CTRL, 32'h1);
    waitSt(ST_PASS_BIT, v);
    chk(v & 32'h3, 32'h3);
    // No report may leave before ready
    keys[7'h15] <= 1'b1;
    repeat (1500) @(posedge clock);
    rd(REG_STATUS, v);
    chk(v & 32'h4, 32'h0);
    keys <= '0;
    chk({31'h0, hostReady}, 32'h0);
    wr(REG_CTRL, 32'h2);
    for (int n = 0; n < 6000 && hostReady !== 1'b1; n++) @(posedge clock);
    chk({31'h0, hostReady}, 32'h1);
    tryKey(7'h0, 7'h15, 4'h0);
    tryKey(KEY_SHIFT, 7'h23, 4'h1);
    tryKey(KEY_ALT, 7'h31, 4'h2);
    tryKey(KEY_CTRL, 7'h42, 4'h8);
    keys[7'h27] <= 1'b1;
    readKey(7'h27, v);
    chk(v & 32'hFFF, 32'h027);
    keys[KEY_SHIFT] <= 1'b1;
    repeat (2600) @(posedge clock);
    readKey(7'h27, v);
    chk(v & 32'hFFF, 32'h0A7);
    keys <= '0;
    repeat (1000) @(posedge clock);
    tryKey(KEY_CAPS, 7'h05, 4'h4);
    rd(REG_STATUS, v);
    chk(v & 32'h8, 32'h0);
    end_sim();
  end
endmodule
